// *** fcp_pkg.sv ***
// constants, register map and command codes of the flash command controller
package fcp_pkg;

   // ------------------------------------------------------------------
   // timing, pclk at 10 MHz
   // ------------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int T_WP_NS = 100;
   localparam int T_RD_NS = 300;
   localparam int T_PROT_US = 100;
   localparam int T_UNPROT_MS = 10;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROT_CYC = (T_PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int UNPROT_CYC_DEF = (T_UNPROT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int POLL_LIMIT_DEF = 65535;

   // ------------------------------------------------------------------
   // register map (byte offsets) and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_RDATA = 8'h10;
   localparam logic [7:0] OFS_PINS = 8'h14;
   localparam logic [2:0] PINS_RST = 3'h4;
   localparam int ST_BUSY = 0;
   localparam int ST_DQ5_ERR = 1;
   localparam int ST_TIMEOUT = 2;
   localparam int ST_UNPROT_FAIL = 3;
   localparam int ST_REJECT = 4;
   localparam int PIN_BYTE = 0;
   localparam int PIN_TEMP_UNPROT = 1;
   localparam int PIN_RESET = 2;

   // ------------------------------------------------------------------
   // coded cycle addresses, as {a16..a0, a_minus1}
   // ------------------------------------------------------------------
   localparam logic [17:0] U1_WORD = {17'h05555, 1'b0};
   localparam logic [17:0] U2_WORD = {17'h02aaa, 1'b0};
   localparam logic [17:0] U1_BYTE = 18'h0aaaa;
   localparam logic [17:0] U2_BYTE = 18'h05555;

   // ------------------------------------------------------------------
   // flash command data
   // ------------------------------------------------------------------
   localparam logic [7:0] D_UNLOCK1 = 8'haa;
   localparam logic [7:0] D_UNLOCK2 = 8'h55;
   localparam logic [7:0] D_READ_RESET = 8'hf0;
   localparam logic [7:0] D_AUTOSELECT = 8'h90;
   localparam logic [7:0] D_PROGRAM = 8'ha0;
   localparam logic [7:0] D_ERASE_SETUP = 8'h80;
   localparam logic [7:0] D_BLOCK_CONFIRM = 8'h30;
   localparam logic [7:0] D_CHIP_CONFIRM = 8'h10;
   localparam logic [7:0] D_SUSPEND = 8'hb0;
   localparam logic [7:0] D_STATUS_MASK = 8'hec;

   // ------------------------------------------------------------------
   // controller orders written to the ctrl register
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      C_READ, C_RESET1, C_RESET3, C_AUTOSEL, C_PROGRAM, C_BLOCK_ERASE,
      C_CHIP_ERASE, C_SUSPEND, C_RESUME, C_PROT_READ, C_UNPROT_ALL
   } fcp_cmd_t;

   typedef enum logic [1:0] {K_WR, K_RD, K_POLL, K_END} fcp_kind_t;

endpackage : fcp_pkg

// *** fcp_bus_cycle.sv ***
// one asynchronous flash bus cycle: address, strobe pulse, data in or out
`timescale 1ns/1ps
module fcp_bus_cycle
   import fcp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic wr,
   input wire logic byte_mode,
   input wire logic [17:0] pin_addr,
   input wire logic [15:0] wdata,
   input wire logic [16:0] len,
   output logic done,
   output logic [15:0] rdata,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [16:0] flash_addr,
   output logic [15:0] flash_dq_o,
   output logic [15:0] flash_dq_oe,
   input wire logic [15:0] flash_dq_i
);

   typedef enum logic [1:0] {B_IDLE, B_SETUP, B_PULSE, B_HOLD} fcp_bstate_t;

   fcp_bstate_t state_q;
   logic wr_q;
   logic [17:0] addr_q;
   logic [15:0] data_q;
   logic [16:0] cnt_q;
   logic [15:0] dq_s1_q;
   logic [15:0] dq_s2_q;

   // ------------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= B_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            B_IDLE: begin
               if (start) begin
                  state_q <= B_SETUP;
               end
            end
            B_SETUP: begin
               state_q <= B_PULSE;
               cnt_q <= len;
            end
            B_PULSE: begin
               if (cnt_q <= 17'h00001) begin
                  state_q <= B_HOLD;
               end else begin
                  cnt_q <= cnt_q - 17'h00001;
               end
            end
            B_HOLD: state_q <= B_IDLE;
            default: state_q <= B_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= 1'b0;
         addr_q <= '0;
         data_q <= '0;
      end else if (state_q == B_IDLE && start) begin
         wr_q <= wr;
         addr_q <= pin_addr;
         data_q <= wdata;
      end
   end

   // ------------------------------------------------------------------
   // read data: pins are asynchronous, two flops before use
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         rdata <= '0;
      end else begin
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
         if (state_q == B_PULSE && cnt_q <= 17'h00001 && !wr_q) begin
            rdata <= dq_s2_q;
         end
      end
   end

   // data stays driven through hold so it is stable at the rising write strobe
   assign done = (state_q == B_HOLD);
   assign flash_ce_n = (state_q == B_IDLE);
   assign flash_we_n = !(state_q == B_PULSE && wr_q);
   assign flash_oe_n = !(state_q == B_PULSE && !wr_q);
   assign flash_addr = addr_q[17:1];
   assign flash_dq_o = byte_mode ? {addr_q[0], 7'h00, data_q[7:0]} : data_q;
   // in byte mode the top data pin carries address bit minus one
   assign flash_dq_oe = (state_q != B_IDLE && wr_q) ? (byte_mode ? 16'h80ff : 16'hffff)
                      : (byte_mode ? 16'h8000 : 16'h0000);

endmodule : fcp_bus_cycle

// *** fcp_ctrl.sv ***
// apb-driven host controller for the flash command, protection and polling interface
// What this block does
// - protect every block before starting the unprotect-all operation
// - unprotect starts on falling write strobe with high voltages; ends 10 ms later
// - unprotect verify reads 00h per block; each block checked separately
// - instructions take one to six bus cycles, the first writes
// - multi-cycle instructions start with two unlock writes; erase confirm repeats them
// - host masks reserved status bits 0, 1 and 4
// - poll only while busy, at programmed address or inside erasing block
// - read reset is f0h alone or after the two unlock writes
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module fcp_ctrl
   import fcp_pkg::*;
#(
   parameter int UNPROT_CYC = UNPROT_CYC_DEF,
   parameter int POLL_LIMIT = POLL_LIMIT_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [16:0] flash_addr,
   output logic [15:0] flash_dq_o,
   output logic [15:0] flash_dq_oe,
   input wire logic [15:0] flash_dq_i,
   output logic flash_byte_n,
   output logic reset_unprotect_pin_low,
   output logic reset_unprotect_pin_hv,
   output logic a9_hv,
   output logic oe_hv,
   output logic ce_hv
);

   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fcp_state_t;

   fcp_state_t state_q;
   fcp_cmd_t cmd_q;
   logic [2:0] idx_q;
   logic [1:0] phase_q;
   logic [4:0] blk_q;
   logic [17:0] addr_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic [2:0] pins_q;
   logic [4:1] flags_q;
   logic [16:0] polls_q;
   logic dq5_seen_q;
   logic [31:0] prdata_q;

   fcp_kind_t kind;
   logic [17:0] st_addr;
   logic [7:0] st_data;
   logic [16:0] st_len;
   logic [17:0] user_pa;
   logic [17:0] u1;
   logic [17:0] u2;
   logic bc_start;
   logic bc_done;
   logic [15:0] bc_rdata;
   logic byte_mode;
   logic erase_poll;
   logic exp_dq7;
   logic poll_ok;
   logic apb_wr;
   logic apb_setup;
   logic mapped;

   assign byte_mode = pins_q[PIN_BYTE];
   assign user_pa = byte_mode ? addr_q : {addr_q[16:0], 1'b0};
   assign u1 = byte_mode ? U1_BYTE : U1_WORD;
   assign u2 = byte_mode ? U2_BYTE : U2_WORD;

   // ------------------------------------------------------------------
   // step table: what each bus cycle of an order is
   // ------------------------------------------------------------------
   always_comb begin
      kind = K_END;
      st_addr = user_pa;
      st_data = 8'h00;
      st_len = 17'(WP_CYC);
      case (cmd_q)
         C_READ: begin
            if (idx_q == 3'd0) begin
               kind = K_RD;
            end
         end
         C_RESET1, C_RESUME: begin
            if (idx_q == 3'd0) begin
               kind = K_WR;
               st_data = (cmd_q == C_RESET1) ? D_READ_RESET : D_BLOCK_CONFIRM;
            end
         end
         C_SUSPEND: begin
            kind = (idx_q == 3'd0) ? K_WR : (idx_q == 3'd1) ? K_POLL : K_END;
            st_data = D_SUSPEND;
         end
         C_UNPROT_ALL: begin
            if (phase_q == 2'd0) begin
               // protect pass over every block address first
               kind = K_WR;
               st_addr = {blk_q, 13'h0000};
               st_len = 17'(PROT_CYC);
            end else if (phase_q == 2'd1) begin
               kind = K_WR;
               st_addr = {1'b0, 1'b1, 2'b00, 1'b1, 13'h0000};
               st_len = 17'(UNPROT_CYC);
            end else if (phase_q == 2'd2) begin
               kind = K_RD;
               st_addr = {blk_q, 5'h00, 1'b1, 4'h0, 3'b100};
               st_len = 17'(RD_CYC);
            end
         end
         default: begin
            // all remaining orders open with the two unlock writes
            if (idx_q == 3'd0 || (idx_q == 3'd3 && (cmd_q == C_BLOCK_ERASE ||
                cmd_q == C_CHIP_ERASE))) begin
               kind = K_WR;
               st_addr = u1;
               st_data = D_UNLOCK1;
            end else if (idx_q == 3'd1 || (idx_q == 3'd4 && (cmd_q == C_BLOCK_ERASE ||
                         cmd_q == C_CHIP_ERASE))) begin
               kind = K_WR;
               st_addr = u2;
               st_data = D_UNLOCK2;
            end else if (idx_q == 3'd2) begin
               kind = K_WR;
               st_addr = u1;
               case (cmd_q)
                  C_RESET3: st_data = D_READ_RESET;
                  C_PROGRAM: st_data = D_PROGRAM;
                  C_AUTOSEL, C_PROT_READ: st_data = D_AUTOSELECT;
                  default: st_data = D_ERASE_SETUP;
               endcase
            end else if (idx_q == 3'd3) begin
               kind = (cmd_q == C_PROGRAM) ? K_WR : (cmd_q == C_RESET3) ? K_END : K_RD;
               st_data = wdata_q[7:0];
               if (cmd_q == C_PROT_READ) begin
                  st_addr = {user_pa[17:3], 2'b10, user_pa[0]};
               end
            end else if (idx_q == 3'd4 && cmd_q == C_PROGRAM) begin
               kind = K_POLL;
            end else if (idx_q == 3'd5 && cmd_q != C_PROGRAM) begin
               kind = K_WR;
               st_addr = (cmd_q == C_CHIP_ERASE) ? u1 : user_pa;
               st_data = (cmd_q == C_CHIP_ERASE) ? D_CHIP_CONFIRM : D_BLOCK_CONFIRM;
            end else if (idx_q == 3'd6) begin
               kind = K_POLL;
            end
         end
      endcase
      if (kind == K_RD || kind == K_POLL) begin
         if (cmd_q != C_UNPROT_ALL) begin
            st_len = 17'(RD_CYC);
         end
      end
   end

   // ------------------------------------------------------------------
   // data polling decision
   // ------------------------------------------------------------------
   assign erase_poll = (cmd_q != C_PROGRAM);
   // program polls for the true bit; erase and suspend wait for one
   assign exp_dq7 = erase_poll ? 1'b1 : wdata_q[7];
   assign poll_ok = (bc_rdata[7] == exp_dq7);
   assign bc_start = (state_q == S_ISSUE) && (kind != K_END);

   // ------------------------------------------------------------------
   // order sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (apb_wr && paddr == OFS_CTRL) begin
                  state_q <= S_ISSUE;
               end
            end
            S_ISSUE: state_q <= (kind == K_END) ? S_IDLE : S_WAIT;
            S_WAIT: begin
               if (bc_done) begin
                  state_q <= S_ISSUE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= '0;
         phase_q <= '0;
         blk_q <= '0;
         polls_q <= '0;
         dq5_seen_q <= 1'b0;
      end else if (state_q == S_IDLE) begin
         idx_q <= '0;
         phase_q <= '0;
         blk_q <= '0;
         polls_q <= '0;
         dq5_seen_q <= 1'b0;
      end else if (state_q == S_WAIT && bc_done) begin
         if (cmd_q == C_UNPROT_ALL) begin
            blk_q <= (phase_q == 2'd1) ? blk_q : blk_q + 5'd1;
            if (phase_q == 2'd1 || blk_q == 5'h1f) begin
               phase_q <= phase_q + 2'd1;
            end
         end else if (kind != K_POLL || poll_ok) begin
            idx_q <= idx_q + 3'd1;
         end else if (dq5_seen_q || polls_q == 17'(POLL_LIMIT - 1)) begin
            // second miss after a dq5 error, or too many reads: give up
            idx_q <= 3'd7;
         end else begin
            // a stuck zero from an all-protected erase ends on the poll limit
            polls_q <= polls_q + 17'd1;
            dq5_seen_q <= bc_rdata[5];
         end
      end
   end

   // ------------------------------------------------------------------
   // status flags; a new order clears them, hardware sets win
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= '0;
      end else begin
         if (state_q == S_IDLE && apb_wr && paddr == OFS_CTRL) begin
            flags_q <= '0;
         end
         if (state_q != S_IDLE && apb_wr && paddr == OFS_CTRL) begin
            flags_q[ST_REJECT] <= 1'b1;
         end
         if (state_q == S_WAIT && bc_done && kind == K_POLL && !poll_ok) begin
            if (dq5_seen_q) begin
               flags_q[ST_DQ5_ERR] <= 1'b1;
            end else if (polls_q == 17'(POLL_LIMIT - 1)) begin
               flags_q[ST_TIMEOUT] <= 1'b1;
            end
         end
         if (state_q == S_WAIT && bc_done && cmd_q == C_UNPROT_ALL && phase_q == 2'd2 &&
             bc_rdata[7:0] != 8'h00) begin
            flags_q[ST_UNPROT_FAIL] <= 1'b1;
         end
      end
   end

   // word-mode reads keep the whole word, byte-mode reads only the low byte; status reads drop the reserved bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (state_q == S_WAIT && bc_done && kind == K_POLL) begin
         rdata_q <= {8'h00, bc_rdata[7:0] & D_STATUS_MASK};
      end else if (state_q == S_WAIT && bc_done && kind == K_RD) begin
         // word mode autoselect bytes arrive with the upper byte at zero
         rdata_q <= byte_mode ? {8'h00, bc_rdata[7:0]} : bc_rdata;
      end
   end

   // high voltages for the programming-equipment unprotect pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a9_hv <= 1'b0;
         oe_hv <= 1'b0;
         ce_hv <= 1'b0;
      end else begin
         a9_hv <= (state_q != S_IDLE) && (cmd_q == C_UNPROT_ALL) && (phase_q != 2'd3);
         oe_hv <= (state_q != S_IDLE) && (cmd_q == C_UNPROT_ALL) && (phase_q <= 2'd1);
         ce_hv <= (state_q != S_IDLE) && (cmd_q == C_UNPROT_ALL) && (phase_q == 2'd1);
      end
   end

   // ------------------------------------------------------------------
   // apb slave, always ready
   // ------------------------------------------------------------------
   assign apb_wr = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) || (paddr == OFS_WDATA) ||
                   (paddr == OFS_STATUS) || (paddr == OFS_RDATA) || (paddr == OFS_PINS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= C_READ;
         addr_q <= '0;
         wdata_q <= '0;
         pins_q <= PINS_RST;
      end else if (apb_wr) begin
         case (paddr)
            OFS_CTRL: begin
               if (state_q == S_IDLE) begin
                  // unknown codes fall back to a plain array read
                  cmd_q <= (pwdata[3:0] > 4'(C_UNPROT_ALL)) ? C_READ : fcp_cmd_t'(pwdata[3:0]);
               end
            end
            OFS_ADDR: addr_q <= pwdata[17:0];
            OFS_WDATA: wdata_q <= pwdata[15:0];
            OFS_PINS: pins_q <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (apb_setup && !pwrite) begin
         case (paddr)
            OFS_CTRL: prdata_q <= {28'h0000000, cmd_q};
            OFS_ADDR: prdata_q <= {14'h0000, addr_q};
            OFS_WDATA: prdata_q <= {16'h0000, wdata_q};
            OFS_STATUS: prdata_q <= {27'h0000000, flags_q, state_q != S_IDLE};
            OFS_RDATA: prdata_q <= {16'h0000, rdata_q};
            OFS_PINS: prdata_q <= {29'h00000000, pins_q};
            default: prdata_q <= '0;
         endcase
      end
   end

   // temporary unprotect holds the reset pin at high voltage until cleared
   assign reset_unprotect_pin_hv = pins_q[PIN_TEMP_UNPROT];
   assign reset_unprotect_pin_low = pins_q[PIN_RESET];
   assign flash_byte_n = !byte_mode;

   fcp_bus_cycle u_cycle (
      .pclk(pclk),
      .presetn(presetn),
      .start(bc_start),
      .wr(kind == K_WR),
      .byte_mode(byte_mode),
      .pin_addr(st_addr),
      .wdata({8'h00, st_data}),
      .len(st_len),
      .done(bc_done),
      .rdata(bc_rdata),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n),
      .flash_addr(flash_addr),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe),
      .flash_dq_i(flash_dq_i)
   );

endmodule : fcp_ctrl

// *** fcp_ctrl_sva.sv ***
// pin protocol checker for the flash command controller
`timescale 1ns/1ps
// ---
// checker
// ---
module fcp_ctrl_sva #(
   parameter int UNPROT_CYC = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [16:0] flash_addr,
   input wire logic [15:0] flash_dq_oe,
   input wire logic flash_byte_n,
   input wire logic a9_hv,
   input wire logic oe_hv,
   input wire logic ce_hv
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // strobe low count; a repetition cannot span pulses this long
   int lo_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lo_q <= 0;
      else lo_q <= flash_we_n ? 0 : lo_q + 1;
   end
   a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n)
      else $error("write strobe outside chip enable");
   a_rw_apart: assert property (!oe_hv |-> flash_oe_n || flash_we_n)
      else $error("read and write strobes both low");
   a_wr_drive: assert property (
      $fell(flash_we_n) && !a9_hv |-> flash_dq_oe[7:0] == 8'hff)
      else $error("write data not driven");
   a_wr_short: assert property (
      $rose(flash_we_n) && !$past(a9_hv) |-> lo_q == 1)
      else $error("write pulse length wrong");
   a_prot_len: assert property (
      $rose(flash_we_n) && $past(a9_hv) && !$past(ce_hv) |-> lo_q == 1000)
      else $error("protect pulse length wrong");
   a_unprot_len: assert property (
      $rose(flash_we_n) && $past(ce_hv) |-> lo_q == UNPROT_CYC)
      else $error("unprotect pulse length wrong");
   a_unprot_pins: assert property (
      $fell(flash_we_n) && ce_hv |-> oe_hv && a9_hv && flash_addr[12] && flash_addr[15])
      else $error("unprotect pin levels wrong");
   a_oe_len: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*3] ##1 flash_oe_n)
      else $error("read pulse length wrong");
   // in byte mode the top data pin is an address input and stays driven
   a_rd_float: assert property (
      !flash_oe_n |-> flash_dq_oe == (flash_byte_n ? 16'h0000 : 16'h8000))
      else $error("data driven during read");
   a_verify_pins: assert property (
      $fell(flash_oe_n) && a9_hv |-> flash_addr[6] && flash_addr[1] && !flash_addr[0])
      else $error("verify address wrong");
   c_unprot: cover property ($fell(flash_we_n) && ce_hv);
   c_prot: cover property ($fell(flash_we_n) && a9_hv && !ce_hv);
   c_read: cover property ($fell(flash_oe_n) && !a9_hv);
endmodule : fcp_ctrl_sva
bind fcp_ctrl fcp_ctrl_sva #(.UNPROT_CYC(UNPROT_CYC)) u_sva (.*);

// *** fcp_flash_model.sv ***
// behavioural flash device facing the controller
`timescale 1ns/1ps
// ---
// command decoder and read data
// ---
module fcp_flash_model (
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [15:0] flash_dq_o,
   input wire logic a9_hv,
   output logic [15:0] flash_dq_i
);
   int step = 0, s = 0, bsy = 0;
   bit asel = 1'b0, er = 1'b0;
   logic [7:0] d, pv = 8'hff;
   logic [15:0] val, last = 16'h0000;
   always @(posedge flash_we_n) begin
      if (!flash_ce_n && !a9_hv) begin
         d = flash_dq_o[7:0];
         s = step;
         step = 0;
         if (s == 3 || (s == 2 && er && (d == 8'h30 || d == 8'h10))) begin
            pv = (s == 3) ? d : 8'hff;
            bsy = 4;
         end
         if (s == 2 && d == 8'ha0) step = 3;
         if (s == 0 && d == 8'haa) step = 1;
         if (s == 1 && d == 8'h55) step = 2;
         er = (s == 2 && d == 8'h80) || (er && step != 0);
         asel = (s == 2 && d == 8'h90) || (asel && step != 0);
      end
   end
   // released bus shows the inverse of the last value, never a stale copy
   always @(posedge flash_oe_n) begin
      last = val;
      if (bsy > 0) bsy = bsy - 1;
   end
   always @* begin
      if (bsy > 0) val = {8'h00, ~pv[7], 7'h00};
      else if (asel || a9_hv) val = 16'h0000;
      else val = {8'h00, pv};
      flash_dq_i = (!flash_oe_n && !flash_ce_n) ? val : ~last;
   end
endmodule : fcp_flash_model

// *** fcp_ctrl_tb.sv ***
// self-checking bench for the flash command controller
`timescale 1ns/1ps
// ---
// stimulus and reference
// ---
module fcp_ctrl_tb;
   import fcp_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, pv = 8'hff;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, se, flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n;
   logic reset_unprotect_pin_low, reset_unprotect_pin_hv, a9_hv, oe_hv, ce_hv;
   logic [16:0] flash_addr;
   logic [15:0] flash_dq_o, flash_dq_oe, flash_dq_i, lfsr = 16'h0734;
   logic [3:0] cs [8] = '{C_BLOCK_ERASE, C_CHIP_ERASE, C_SUSPEND, C_AUTOSEL, C_PROT_READ,
                          C_RESET1, C_RESET3, C_RESUME};
   int err_count = 0;
   int n_checks = 0;
   always #50 pclk = ~pclk;
   fcp_ctrl #(.UNPROT_CYC(20), .POLL_LIMIT(8)) u_dut (.*);
   fcp_flash_model u_flash (.*);
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   task automatic finish_test;
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
      if (pready !== 1'b1) finish_test;
   endtask : apb
   task automatic idle(input int lim);
      for (int i = 0; i < lim; i++) begin
         apb(1'b0, OFS_STATUS, 32'h0);
         if (rd[ST_BUSY] === 1'b0) return;
      end
      chk(rd & 32'h1, 32'h0);
      finish_test;
   endtask : idle
   task automatic order(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, OFS_ADDR, a);
      apb(1'b1, OFS_WDATA, d);
      apb(1'b1, OFS_CTRL, {28'h0, c});
      idle(20000);
   endtask : order
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_PINS, 32'h0);
      chk(rd, {29'h0, PINS_RST});
      apb(1'b0, 8'h18, 32'h0);
      chk(rd + {31'h0, se}, 32'h1);
      // every byte and temporary unprotect pin mix, each with a random program and read back
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_PINS, {30'h0, i[1:0]});
         @(negedge pclk);
         chk({29'h0, reset_unprotect_pin_low, reset_unprotect_pin_hv, flash_byte_n},
             {30'h0, i[1], ~i[0]});
         lfsr = nxt(lfsr);
         pv = lfsr[7:0];
         order(C_PROGRAM, {16'h0, lfsr}, {16'h0, lfsr});
         chk(rd, 32'h0);
         apb(1'b0, OFS_RDATA, 32'h0);
         chk(rd, {24'h0, pv & D_STATUS_MASK});
         order(C_READ, {16'h0, lfsr}, 32'h0);
         apb(1'b0, OFS_RDATA, 32'h0);
         chk(rd, {24'h0, pv});
      end
      for (int k = 0; k < 8; k++) begin
         order(cs[k], 32'h0, 32'h0);
         chk(rd, 32'h0);
         apb(1'b0, OFS_RDATA, 32'h0);
         if (k < 5) chk(rd, (k < 3) ? {24'h0, D_STATUS_MASK} : 32'h0);
      end
      order(4'hf, 32'h0, 32'h0);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'hff);
      // second order while busy must be turned away
      apb(1'b1, OFS_CTRL, {28'h0, C_PROGRAM});
      apb(1'b1, OFS_CTRL, {28'h0, C_READ});
      idle(200);
      chk(rd, 32'h1 << ST_REJECT);
      order(C_UNPROT_ALL, 32'h0, 32'h0);
      chk(rd, 32'h0);
      finish_test;
   end
endmodule : fcp_ctrl_tb
